//--- hdl/shfr_frame_rx.sv
// Serial host frame receiver: framing, reply framer, line driver and flow control
`timescale 1ns/1ps
module shfr_frame_rx #(
  parameter int TIMEOUT_CYCLES = shfr_pkg::TIMEOUT_CYC,
  parameter int FIFO_DEPTH     = shfr_pkg::FIFO_DEPTH,
  parameter int CLK_HZ         = shfr_pkg::CLK_HZ
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       rxd,
  input  wire logic       cts,
  input  wire logic [3:0] addr_sw,
  input  wire logic       crc_sw,
  input  wire logic [2:0] baud_sel,
  output logic            rts,
  output logic            txd,
  output logic            tx_oe,
  output logic            out_valid,
  output logic [7:0]      out_data,
  output logic            out_first,
  output logic            out_last,
  input  wire logic       out_ready,
  output logic            frame_done,
  output logic            frame_good,
  output logic            frame_global,
  output logic            reply_wait,
  input  wire logic       reply_start,
  input  wire logic [7:0] reply_len,
  input  wire logic       reply_valid,
  input  wire logic [7:0] reply_data,
  output logic            reply_ready
);

  if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES must be at least 1");
  end
  if (FIFO_DEPTH <= shfr_pkg::RTS_MARGIN) begin : g_bad_fifo
    $error("FIFO_DEPTH too small for the flow-control margin");
  end
  if (CLK_HZ < shfr_pkg::OVERSAMPLE * shfr_pkg::BAUD_CRC_OFF) begin : g_bad_clk
    $error("CLK_HZ too low for the fastest baud rate");
  end

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ****************
  // Pin synchronisers
  // ****************
  logic [8:0] pins_meta_q;
  logic [8:0] pins_sync_q;
  logic [3:0] addr_s;
  logic       crc_on;
  logic [2:0] baud_s;
  logic       cts_s;

  always_ff @(posedge clock) begin
    if (rst) begin
      pins_meta_q <= 9'h000;
      pins_sync_q <= 9'h000;
    end else begin
      pins_meta_q <= {cts, crc_sw, baud_sel, addr_sw};
      pins_sync_q <= pins_meta_q;
    end
  end

  assign addr_s = pins_sync_q[3:0];   // RQ2
  assign baud_s = pins_sync_q[6:4];
  assign crc_on = pins_sync_q[7];
  assign cts_s  = pins_sync_q[8];

  // ****************
  // Baud rate ticks
  // ****************
  logic [15:0] div_lim;
  logic [15:0] div_cnt_q;
  logic        tick16_q;
  logic [3:0]  sub_q;
  logic        bit_tick;

  assign div_lim  = shfr_pkg::baud_div(CLK_HZ, crc_on, baud_s);  // RQ13
  assign bit_tick = tick16_q && (sub_q == 4'hF);

  always_ff @(posedge clock) begin
    if (rst) begin
      div_cnt_q <= 16'h0000;
      tick16_q  <= 1'b0;
      sub_q     <= 4'h0;
    end else begin
      tick16_q <= 1'b0;
      if (div_cnt_q >= div_lim - 16'h0001) begin
        div_cnt_q <= 16'h0000;
        tick16_q  <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
      end
      if (tick16_q) begin
        sub_q <= sub_q + 4'h1;
      end
    end
  end

  // ****************
  // Receiver and byte buffer
  // ****************
  logic                    rx_valid;
  shfr_pkg::shfr_rx_byte_t rx_byte;
  logic                    fifo_in_ready;
  logic                    fifo_valid;
  shfr_pkg::shfr_rx_byte_t fifo_byte;
  logic [LW-1:0]           fifo_level;
  logic                    pop;
  logic                    ovr_q;

  shfr_uart_rx u_rx (
    .clock     (clock),
    .rst       (rst),
    .rxd       (rxd),
    .tick16    (tick16_q),
    .parity_en (!crc_on),            // RQ10
    .valid_q   (rx_valid),
    .byte_q    (rx_byte)
  );

  shfr_fifo #(
    .WIDTH ($bits(shfr_pkg::shfr_rx_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (rx_valid),
    .in_data   (rx_byte),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_byte),
    .out_ready (pop),
    .level     (fifo_level)
  );

  // Overrun spoils the frame in progress
  always_ff @(posedge clock) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else if (rx_valid && !fifo_in_ready) begin
      ovr_q <= 1'b1;
    end else if (pop) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rts <= 1'b0;
    end else begin
      rts <= fifo_level < LW'(FIFO_DEPTH - shfr_pkg::RTS_MARGIN);  // RQ18
    end
  end

  // ****************
  // Frame parser
  // ****************
  shfr_pkg::shfr_rx_state_t rx_st_q;
  logic [7:0]  b;
  logic        e;
  logic [15:0] crc_q;
  logic [7:0]  crc_hi_q;
  logic [7:0]  remain_q;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_now;
  logic        bad_q;
  logic        mine_q;
  logic        glob_q;
  logic        first_q;
  logic        fin_now;
  logic        fin_good;
  logic        to_fire;
  logic [31:0] to_cnt_q;

  assign pop = fifo_valid && (!out_valid || out_ready);
  assign b   = fifo_byte.data;
  assign e   = fifo_byte.err || ovr_q;
  assign cmd_now = first_q ? b : cmd_q;

  always_comb begin
    fin_now = 1'b0;
    if (pop) begin
      case (rx_st_q)
        shfr_pkg::RX_COUNT:  fin_now = (b == 8'h00) && !crc_on;
        shfr_pkg::RX_BODY:   fin_now = (remain_q == 8'h01) && !crc_on;
        shfr_pkg::RX_CRC_LO: fin_now = 1'b1;
        default:             fin_now = 1'b0;
      endcase
    end
    fin_good = !(bad_q || e) && (rx_st_q != shfr_pkg::RX_COUNT)
               && (!crc_on || ({crc_hi_q, b} == crc_q));  // RQ8
  end

  assign to_fire = (rx_st_q != shfr_pkg::RX_HUNT) && (to_cnt_q == 32'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (rst || pop || rx_st_q == shfr_pkg::RX_HUNT) begin
      to_cnt_q <= 32'h0000_0000;
    end else begin
      to_cnt_q <= to_cnt_q + 32'h0000_0001;  // RQ7
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_st_q  <= shfr_pkg::RX_HUNT;
      crc_q    <= shfr_pkg::CRC_INIT;
      crc_hi_q <= 8'h00;
      remain_q <= 8'h00;
      cmd_q    <= 8'h00;
      bad_q    <= 1'b0;
      mine_q   <= 1'b0;
      glob_q   <= 1'b0;
      first_q  <= 1'b0;
    end else if (to_fire) begin
      rx_st_q <= shfr_pkg::RX_HUNT;  // RQ23
    end else if (pop) begin
      bad_q <= bad_q || e;
      case (rx_st_q)
        shfr_pkg::RX_HUNT: begin
          if (b == shfr_pkg::FRAME_START && !e) begin  // RQ1 RQ6
            crc_q   <= shfr_pkg::crc_step(shfr_pkg::CRC_INIT, b);  // RQ17 RQ26
            bad_q   <= 1'b0;
            rx_st_q <= shfr_pkg::RX_ADDR;
          end
        end
        shfr_pkg::RX_ADDR: begin
          crc_q   <= shfr_pkg::crc_step(crc_q, b);
          mine_q  <= (b == {4'h0, addr_s}) || (b == shfr_pkg::ADDR_GLOBAL);  // RQ2 RQ3 RQ22
          glob_q  <= (b == shfr_pkg::ADDR_GLOBAL);
          rx_st_q <= shfr_pkg::RX_COUNT;
        end
        shfr_pkg::RX_COUNT: begin
          crc_q    <= shfr_pkg::crc_step(crc_q, b);
          remain_q <= b;  // RQ5
          first_q  <= 1'b1;
          if (b != 8'h00) begin
            rx_st_q <= shfr_pkg::RX_BODY;
          end else begin
            bad_q   <= 1'b1;
            rx_st_q <= crc_on ? shfr_pkg::RX_CRC_HI : shfr_pkg::RX_HUNT;
          end
        end
        shfr_pkg::RX_BODY: begin
          crc_q    <= shfr_pkg::crc_step(crc_q, b);
          remain_q <= remain_q - 8'h01;
          first_q  <= 1'b0;
          if (first_q) begin
            cmd_q <= b;
          end
          if (remain_q == 8'h01) begin
            rx_st_q <= crc_on ? shfr_pkg::RX_CRC_HI : shfr_pkg::RX_HUNT;  // RQ11 RQ6
          end
        end
        shfr_pkg::RX_CRC_HI: begin
          crc_hi_q <= b;  // RQ26
          rx_st_q  <= shfr_pkg::RX_CRC_LO;
        end
        shfr_pkg::RX_CRC_LO: begin
          rx_st_q <= shfr_pkg::RX_HUNT;
        end
        default: begin
          rx_st_q <= shfr_pkg::RX_HUNT;
        end
      endcase
    end
  end

  // ****************
  // Delivery of command and data
  // ****************
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_first <= 1'b0;
      out_last  <= 1'b0;
    end else if (pop && rx_st_q == shfr_pkg::RX_BODY && mine_q && !to_fire) begin
      out_valid <= 1'b1;
      out_data  <= b;
      out_first <= first_q;
      out_last  <= (remain_q == 8'h01);
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // ****************
  // Frame verdict and reply requests
  // ****************
  logic ack_req_q;
  logic tx_start;
  logic user_start;
  shfr_pkg::shfr_tx_state_t tx_st_q;

  assign user_start = (tx_st_q == shfr_pkg::TX_IDLE) && !ack_req_q && reply_start && reply_wait;  // RQ9
  assign tx_start   = (tx_st_q == shfr_pkg::TX_IDLE) && (ack_req_q || user_start);

  always_ff @(posedge clock) begin
    if (rst) begin
      frame_done   <= 1'b0;
      frame_good   <= 1'b0;
      frame_global <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (to_fire && mine_q) begin
        frame_done <= 1'b1;
        frame_good <= 1'b0;  // RQ23
      end else if (fin_now && mine_q) begin
        frame_done   <= 1'b1;
        frame_good   <= fin_good;  // RQ8
        frame_global <= glob_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_req_q  <= 1'b0;
      reply_wait <= 1'b0;
    end else begin
      if (tx_start && ack_req_q) begin
        ack_req_q <= 1'b0;
      end
      if (user_start) begin
        reply_wait <= 1'b0;
      end
      if (!to_fire && fin_now && mine_q && fin_good && !glob_q) begin  // RQ4
        if (cmd_now == shfr_pkg::CMD_STATUS || cmd_now == shfr_pkg::CMD_PARAM) begin
          reply_wait <= 1'b1;
        end else begin
          ack_req_q <= 1'b1;  // RQ24
        end
      end
    end
  end

  // ****************
  // Reply framer
  // ****************
  logic        auto_q;
  logic [7:0]  len_q;
  logic [7:0]  left_q;
  logic [1:0]  hidx_q;
  logic [15:0] tx_crc_q;
  logic        nb_valid;
  logic [7:0]  nb;
  logic        load;
  logic        ser_busy_q;

  always_comb begin
    nb_valid = 1'b0;
    nb       = 8'h00;
    case (tx_st_q)
      shfr_pkg::TX_HEAD: begin
        nb_valid = 1'b1;
        nb = (hidx_q == 2'h0) ? shfr_pkg::FRAME_START : (hidx_q == 2'h1) ? {4'h0, addr_s} : len_q;
      end
      shfr_pkg::TX_BODY: begin
        nb_valid = auto_q || (reply_valid && reply_ready);
        nb       = auto_q ? shfr_pkg::CMD_ACK : reply_data;
      end
      shfr_pkg::TX_CRC: begin
        nb_valid = 1'b1;
        nb       = hidx_q[0] ? tx_crc_q[7:0] : tx_crc_q[15:8];  // RQ26
      end
      default: begin
        nb_valid = 1'b0;
        nb       = 8'h00;
      end
    endcase
  end

  assign load = nb_valid && !ser_busy_q && cts_s;  // RQ20

  always_ff @(posedge clock) begin
    if (rst) begin
      reply_ready <= 1'b0;
    end else begin
      reply_ready <= (tx_st_q == shfr_pkg::TX_BODY) && !auto_q && !ser_busy_q && cts_s && !load;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_st_q  <= shfr_pkg::TX_IDLE;
      auto_q   <= 1'b0;
      len_q    <= 8'h00;
      left_q   <= 8'h00;
      hidx_q   <= 2'h0;
      tx_crc_q <= shfr_pkg::CRC_INIT;
      tx_oe    <= 1'b0;
    end else begin
      case (tx_st_q)
        shfr_pkg::TX_IDLE: begin
          if (tx_start) begin
            auto_q   <= ack_req_q;
            len_q    <= ack_req_q ? 8'h01 : reply_len;
            tx_st_q  <= shfr_pkg::TX_HEAD;
            hidx_q   <= 2'h0;
            tx_crc_q <= shfr_pkg::CRC_INIT;  // RQ17
            tx_oe    <= 1'b1;  // RQ21
          end
        end
        shfr_pkg::TX_HEAD: begin
          if (load) begin
            tx_crc_q <= shfr_pkg::crc_step(tx_crc_q, nb);
            hidx_q   <= hidx_q + 2'h1;
            if (hidx_q == 2'h2) begin
              left_q <= len_q;
              hidx_q <= 2'h0;
              if (len_q != 8'h00) begin
                tx_st_q <= shfr_pkg::TX_BODY;
              end else begin
                tx_st_q <= crc_on ? shfr_pkg::TX_CRC : shfr_pkg::TX_END;
              end
            end
          end
        end
        shfr_pkg::TX_BODY: begin
          if (load) begin
            tx_crc_q <= shfr_pkg::crc_step(tx_crc_q, nb);
            left_q   <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              tx_st_q <= crc_on ? shfr_pkg::TX_CRC : shfr_pkg::TX_END;  // RQ11
            end
          end
        end
        shfr_pkg::TX_CRC: begin
          if (load) begin
            hidx_q <= hidx_q + 2'h1;
            if (hidx_q[0]) begin
              tx_st_q <= shfr_pkg::TX_END;
            end
          end
        end
        shfr_pkg::TX_END: begin
          if (!ser_busy_q) begin
            tx_oe   <= 1'b0;  // RQ21
            tx_st_q <= shfr_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_st_q <= shfr_pkg::TX_IDLE;
          tx_oe   <= 1'b0;
        end
      endcase
    end
  end

  // ****************
  // Line serializer
  // ****************
  logic [10:0] ser_q;
  logic [3:0]  ser_cnt_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      ser_q      <= 11'h7FF;
      ser_cnt_q  <= 4'h0;
      ser_busy_q <= 1'b0;
      txd        <= 1'b1;
    end else if (load) begin
      ser_busy_q <= 1'b1;
      ser_q      <= crc_on ? {2'b11, nb, 1'b0} : {1'b1, ^nb, nb, 1'b0};  // RQ10 RQ12
      ser_cnt_q  <= crc_on ? 4'hA : 4'hB;
    end else if (ser_busy_q && bit_tick) begin
      if (ser_cnt_q != 4'h0) begin
        txd       <= ser_q[0];
        ser_q     <= {1'b1, ser_q[10:1]};
        ser_cnt_q <= ser_cnt_q - 4'h1;
      end else begin
        txd        <= 1'b1;
        ser_busy_q <= 1'b0;
      end
    end
  end

endmodule

//--- hdl/shfr_pkg.sv
// Constants, carrier types and checksum arithmetic for the serial frame receiver
// Functional notes
// RQ1: Frame: start, address, count, command, data, checksum
// RQ2: Board address from four switches, 0 to 15
// RQ3: All-ones address reaches every board
// RQ4: Global frames get no reply
// RQ5: Count covers command plus data only
// RQ6: Bytes beyond the count are discarded
// RQ7: Short frames wait for the time-out
// RQ8: Bad checksum drops the whole frame
// RQ9: Transmit only in reply to a request
// RQ10: Checksum switch off: even parity, no checksum
// RQ11: Checksum switch on: no parity, two-byte checksum
// RQ12: Eight data bits, one stop bit
// RQ13: Six jumpers select baud, times four without checksum
// RQ14: Shift checksum left, keep top bit
// RQ15: Add byte into low half, drop carry
// RQ16: On carry, XOR word with A097
// RQ17: Checksum starts at zero per frame
// RQ18: Request-to-send high while ready to accept
// RQ19: Host gates its transmitter with request-to-send
// RQ20: Host holds clear-to-send high when ready
// RQ21: Line driver enabled only while replying
// RQ22: Up to sixteen boards share the loop
// RQ23: Over 200 ms between bytes aborts frame
// RQ24: Other commands answered with acknowledge frame
// RQ25: Host retries after 50 ms without reply
// RQ26: Checksum over all prior bytes, high first
package shfr_pkg;

  localparam logic [7:0]  FRAME_START   = 8'h02;
  localparam logic [7:0]  ADDR_GLOBAL   = 8'hFF;
  localparam logic [7:0]  CMD_ACK       = 8'h06;
  localparam logic [7:0]  CMD_STATUS    = 8'h05;
  localparam logic [7:0]  CMD_PARAM     = 8'h12;
  localparam logic [15:0] CRC_POLY      = 16'hA097;
  localparam logic [15:0] CRC_INIT      = 16'h0000;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          OVERSAMPLE    = 16;
  localparam int          BAUD_CRC_ON   = 9600;
  localparam int          BAUD_CRC_OFF  = 38400;
  localparam logic [2:0]  BAUD_SEL_MAX  = 3'h5;
  localparam logic [2:0]  BAUD_SEL_DEF  = 3'h2;
  localparam int          TIMEOUT_MS    = 200;
  localparam int          TIMEOUT_CYC   = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          RTS_MARGIN    = 2;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } shfr_rx_byte_t;

  typedef enum logic [2:0] {RX_HUNT, RX_ADDR, RX_COUNT, RX_BODY, RX_CRC_HI, RX_CRC_LO} shfr_rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_HEAD, TX_BODY, TX_CRC, TX_END} shfr_tx_state_t;

  // One checksum step per byte
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] s;
    s      = {crc[14:0], 1'b0};                 // RQ14
    s[7:0] = s[7:0] + b;                        // RQ15
    return crc[15] ? (s ^ CRC_POLY) : s;        // RQ16
  endfunction

  // Clock cycles per oversampling tick for the selected rate
  function automatic logic [15:0] baud_div(input int clk_hz, input logic crc_on, input logic [2:0] sel);
    int base;
    int idx;
    base = crc_on ? BAUD_CRC_ON : BAUD_CRC_OFF;  // RQ13
    idx  = (sel > BAUD_SEL_MAX) ? int'(BAUD_SEL_DEF) : int'(sel);
    return 16'(clk_hz / ((base >> idx) * OVERSAMPLE));
  endfunction

endpackage

//--- hdl/shfr_fifo.sv
// Byte FIFO with registered read data
`timescale 1ns/1ps
module shfr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     in_valid,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          in_ready,
  output logic                          out_valid,
  output logic [WIDTH-1:0]              out_data,
  input  wire logic                     out_ready,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             take;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign take     = (cnt_q != '0) && (!out_valid || out_ready);
  assign level    = cnt_q;

  // ****************
  // Storage
  // ****************
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (take) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(take);
    end
  end

  // ****************
  // Output register
  // ****************
  always_ff @(posedge clock) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (take) begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rd_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

//--- hdl/shfr_uart_rx.sv
// Oversampling serial byte receiver with optional even parity
`timescale 1ns/1ps
module shfr_uart_rx (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  rxd,
  input  wire logic                  tick16,
  input  wire logic                  parity_en,
  output logic                       valid_q,
  output shfr_pkg::shfr_rx_byte_t    byte_q
);
  logic       rx_meta_q;
  logic       rx_sync_q;
  logic       busy_q;
  logic [3:0] phase_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic       par_q;
  logic [3:0] stop_idx;

  assign stop_idx = parity_en ? 4'hA : 4'h9;

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rxd;
      rx_sync_q <= rx_meta_q;
    end
  end

  // ****************
  // Bit sampling at mid-cell
  // ****************
  always_ff @(posedge clock) begin
    if (rst) begin
      valid_q <= 1'b0;
      byte_q  <= '0;
      busy_q  <= 1'b0;
      phase_q <= 4'h0;
      bit_q   <= 4'h0;
      shift_q <= 8'h00;
      par_q   <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (tick16) begin
        if (!busy_q) begin
          if (!rx_sync_q) begin
            busy_q  <= 1'b1;
            phase_q <= 4'h0;
            bit_q   <= 4'h0;
            par_q   <= 1'b0;
          end
        end else begin
          phase_q <= phase_q + 4'h1;
          if (phase_q == 4'h7) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h0) begin
              busy_q <= !rx_sync_q;
            end else if (bit_q <= 4'h8) begin
              shift_q <= {rx_sync_q, shift_q[7:1]};  // RQ12
              par_q   <= par_q ^ rx_sync_q;
            end else if (bit_q < stop_idx) begin
              par_q   <= par_q ^ rx_sync_q;          // RQ10
            end else begin
              valid_q     <= 1'b1;
              byte_q.data <= shift_q;
              byte_q.err  <= !rx_sync_q || (parity_en && par_q);
              busy_q      <= 1'b0;
            end
          end
        end
      end
    end
  end

endmodule

//--- sim/shfr_frame_rx_chk.sv
// Port assertions for the serial frame receiver
`timescale 1ns/1ps
module shfr_frame_rx_chk (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       rts,
  input wire logic       txd,
  input wire logic       tx_oe,
  input wire logic       out_valid,
  input wire logic [7:0] out_data,
  input wire logic       out_ready,
  input wire logic       frame_done,
  input wire logic       frame_good,
  input wire logic       frame_global,
  input wire logic       reply_wait,
  input wire logic       reply_start
);
  logic armed_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Reply permitted once a good non-global frame or user reply is pending
  always_ff @(posedge clock) begin
    if (rst || $fell(tx_oe)) begin
      armed_q <= 1'b0;
    end else if ((frame_done && frame_good && !frame_global) || (reply_start && reply_wait)) begin
      armed_q <= 1'b1;
    end
  end

  chk_line_idle_high: assert property (!tx_oe |-> txd) else $error("txd low with driver off");
  chk_tx_on_request: assert property ($rose(tx_oe) |-> armed_q) else $error("reply without request");
  chk_global_silent: assert property (frame_done && frame_global |=> !$rose(tx_oe) [*8]) else $error("global reply");
  chk_bad_silent: assert property (frame_done && !frame_good |=> !$rose(tx_oe) [*8]) else $error("bad frame reply");
  chk_ack_follows: assert property (frame_done && frame_good && !frame_global
    |-> ##[1:8] (tx_oe || reply_wait)) else $error("no reply started");
  chk_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("out lost");
  chk_done_pulse: assert property (frame_done |=> !frame_done) else $error("frame_done too long");
  chk_rts_reset: assert property (disable iff (1'b0) rst |=> !rts) else $error("rts high in reset");

  cov_good: cover property (frame_done && frame_good);
  cov_global: cover property (frame_done && frame_global);
  cov_reply: cover property ($rose(tx_oe));
endmodule

//--- sim/shfr_host.sv
// Host side of the serial link: sends frame bytes, decodes reply bytes
`timescale 1ns/1ps
module shfr_host (
  input  wire logic clock,
  input  wire logic txd,
  input  wire logic tx_oe,
  input  wire logic rts,
  output logic      rxd,
  output logic      cts
);
  localparam int BIT_CYC = 96;
  wire line = tx_oe ? txd : 1'b1;

  initial begin
    rxd = 1'b1;
    cts = 1'b1;
  end

  task automatic send(input logic [7:0] d);
    logic [10:0] f;
    while (!rts) @(posedge clock);
    f = {1'b1, ^d, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge clock);
    end
  endtask

  task automatic recv(output logic [31:0] w);
    logic [7:0] b;
    for (int k = 0; k < 4; k++) begin
      while (line) @(negedge clock);
      repeat (BIT_CYC / 2) @(negedge clock);
      for (int i = 0; i < 10; i++) begin
        repeat (BIT_CYC) @(negedge clock);
        if (i < 8) begin
          b[i] = line;
        end
      end
      w = {w[23:0], b};
    end
  endtask
endmodule

//--- sim/shfr_frame_rx_test.sv
// Self-checking bench for the serial frame receiver
`timescale 1ns/1ps
module shfr_frame_rx_test;
  logic        clock, rst, rxd, cts, crc_sw, out_ready, rts, txd, tx_oe, out_valid, out_first, out_last;
  logic        frame_done, frame_good, frame_global, reply_wait, reply_start, reply_valid, reply_ready;
  logic        good_l, glob_l;
  logic [3:0]  addr_sw;
  logic [2:0]  baud_sel;
  logic [7:0]  out_data, reply_len, reply_data, last_out;
  logic [31:0] w;
  int          error_cnt, cmp_count, cyc, n_out, done_n;

  shfr_frame_rx #(.TIMEOUT_CYCLES(2000), .CLK_HZ(4_000_000)) i_shfr_frame_rx (.clock(clock), .rst(rst), .rxd(rxd),
    .cts(cts), .addr_sw(addr_sw), .crc_sw(crc_sw), .baud_sel(baud_sel), .rts(rts), .txd(txd), .tx_oe(tx_oe),
    .out_valid(out_valid), .out_data(out_data), .out_first(out_first), .out_last(out_last),
    .out_ready(out_ready), .frame_done(frame_done), .frame_good(frame_good), .frame_global(frame_global),
    .reply_wait(reply_wait), .reply_start(reply_start), .reply_len(reply_len), .reply_valid(reply_valid),
    .reply_data(reply_data), .reply_ready(reply_ready));
  shfr_host i_shfr_host (.clock(clock), .txd(txd), .tx_oe(tx_oe), .rts(rts), .rxd(rxd), .cts(cts));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (out_valid && out_ready) begin
      n_out <= n_out + 1;
      last_out <= out_data;
    end
    if (frame_done) begin
      done_n <= done_n + 1;
      good_l <= frame_good;
      glob_l <= frame_global;
    end
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic frame(input logic [39:0] f, input int n);
    n_out = 0;
    done_n = 0;
    for (int i = 0; i < n; i++)
      i_shfr_host.send(f[39-8*i -: 8]);
  endtask

  task automatic t_ack();
    fork
      frame(40'h0200011400, 4);
      i_shfr_host.recv(w);
    join
    check("ack", w, 32'h02000106);
    check("cmd", {good_l, glob_l, last_out}, 10'h214);
  endtask

  task automatic t_surplus();
    @(posedge clock);
    addr_sw <= 4'h5;
    out_ready <= 1'b0;
    frame(40'h0205011377, 5);
    out_ready <= 1'b1;
    repeat (99) @(negedge clock);
    check("surplus", {done_n[3:0], n_out[3:0], last_out}, 16'h1113);
    while (tx_oe) @(negedge clock);
  endtask

  task automatic t_global();
    frame(40'h02FF011300, 4);
    repeat (99) @(negedge clock);
    check("global", {done_n[3:0], glob_l, tx_oe}, 6'h06);
  endtask

  task automatic t_short();
    frame(40'h0205031400, 4);
    check("pending", done_n, 0);
    repeat (3000) @(negedge clock);
    check("short", {done_n[3:0], good_l}, 5'h02);
  endtask

  task automatic t_status();
    frame(40'h0205010500, 4);
    repeat (99) @(negedge clock);
    check("wait", {reply_wait, tx_oe}, 2'h2);
    fork
      i_shfr_host.recv(w);
      begin
        @(posedge clock);
        reply_start <= 1'b1;
        reply_len <= 8'h01;
        reply_valid <= 1'b1;
        reply_data <= 8'h53;
        @(posedge clock);
        reply_start <= 1'b0;
        @(posedge clock);
        while (!reply_ready) @(posedge clock);
        reply_valid <= 1'b0;
      end
    join
    check("status", w, 32'h02050153);
  endtask

  initial begin
    rst = 1'b1;
    crc_sw = 1'b0;
    baud_sel = 3'h0;
    addr_sw = 4'h0;
    out_ready = 1'b1;
    reply_start = 1'b0;
    reply_len = 8'h00;
    reply_valid = 1'b0;
    reply_data = 8'h00;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (10) @(negedge clock);
    check("rts", rts, 1'b1);
    t_ack();
    t_surplus();
    t_global();
    t_short();
    t_status();
    give_verdict();
  end
endmodule

bind shfr_frame_rx shfr_frame_rx_chk i_shfr_frame_rx_chk (.clock(clock), .rst(rst), .rts(rts), .txd(txd),
  .tx_oe(tx_oe), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .frame_done(frame_done),
  .frame_good(frame_good), .frame_global(frame_global), .reply_wait(reply_wait), .reply_start(reply_start));
